// ==== rtl/sscs_pkg.sv ====
`default_nettype none
package sscs_pkg;
  // Line rate and clock
  localparam int unsigned CLK_HZ     = 250_000_000;
  localparam int unsigned BAUD       = 1050;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD;
  localparam int unsigned UNITY_STOP_BITS = 1;
  localparam int unsigned STOP_CYCLES = BIT_CYCLES * UNITY_STOP_BITS;

  // Character layout
  localparam int unsigned LEVELS          = 8;
  localparam int unsigned BASIC_ELEMENTS  = 6;
  localparam int unsigned BASIC_FRAME     = 10;
  localparam int unsigned CODE_MIN        = 5;
  localparam logic [2:0]  LAST_LEVEL      = 3'h7;
  localparam logic [1:0]  LEN_SEL_8       = 2'h3;
  localparam logic        MARK            = 1'b1;
  localparam logic        SPACE           = 1'b0;
  localparam logic [7:0]  ALL_MARK        = 8'hFF;

  // Character buffer
  localparam int unsigned FIFO_DEPTH = 8;

  typedef enum logic [1:0] {
    ST_STOP  = 2'b00,
    ST_START = 2'b01,
    ST_DATA  = 2'b10
  } sscs_state_t;

  typedef struct packed {
    logic       universal;
    logic [1:0] len_sel;
    logic [7:0] levels;
  } sscs_char_t;
endpackage
`default_nettype wire

// ==== rtl/sscs_serializer.sv ====
`timescale 1ns/100ps
`default_nettype none

module sscs_fifo #(
  parameter int unsigned WIDTH = 11,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = count_reg != (AW+1)'(DEPTH);
  assign out_valid = count_reg != '0;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// Notes on behaviour
// R01: The basic variant holds six elements and sends a ten-bit character.
// R02: In the basic variant level zero, right after start, is always mark.
// R03: In the basic variant levels one to five carry the information.
// R04: After level five the basic variant sends levels six, seven and stop.
// R05: The universal variant has eight elements and takes up to eight info bits.
// R06: In the universal variant an unused level zero goes out as space.
// R07: In the universal variant unused levels six and seven go out as mark.
// R08: Basic is five-level only; universal takes five to eight levels.
// R09: All levels of a character are captured together when tape is sensed.
// R10: Captured bits go out one per bit time until all have been sent.
// R11: The register is cleared before the next character is taken in.
// R12: The reader's character-rate pulse starts the stop interval.
// R13: A separate bit-rate oscillator advances the shift register.
// R14: The oscillator halts in the stop interval and restarts at start.
// R15: The output goes to space for the start bit before the code loads; here both happen on the same start_now edge.
// R16: With no character the line holds continuous mark, no advances.
// R17: Each start and data bit lasts one bit period, level zero first.
module sscs_serializer #(
  parameter int unsigned BIT_CYCLES = sscs_pkg::BIT_CYCLES
) (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     reset_n,
  // Tape reader
  input  wire logic [sscs_pkg::LEVELS-1:0] tape_levels,
  input  wire logic                     universal_contact,
  input  wire logic                     pickup_pulse,
  output logic                          reader_ready,
  // Variant straps
  input  wire logic                     universal_sel,
  input  wire logic [1:0]               len_sel,
  // Line
  output logic                          serial_out,
  output logic                          tx_active
);
  import sscs_pkg::*;

  localparam int unsigned OSC_W = $clog2(BIT_CYCLES + 1);
  localparam logic [OSC_W-1:0] OSC_MAX = OSC_W'(BIT_CYCLES - 1);
  localparam int unsigned PIN_W = LEVELS + 5;
  localparam int unsigned STOP_LEN = BIT_CYCLES * UNITY_STOP_BITS;

  logic [PIN_W-1:0] pin_meta_reg;
  logic [PIN_W-1:0] pin_sync_reg;
  logic             pick_prev_reg;
  logic [7:0]       lvl_s;
  logic             univ_s;
  logic             pick_s;
  logic             usel_s;
  logic [1:0]       lsel_s;
  logic             pick_evt;

  sscs_state_t      state_reg;
  logic [7:0]       shift_reg;
  logic             out_reg;
  logic [2:0]       idx_reg;
  logic [OSC_W-1:0] osc_cnt_reg;
  logic [OSC_W-1:0] stop_cnt_reg;
  logic             stop_run_reg;
  logic             pick_pend_reg;
  logic             bit_tick;
  logic             stop_done;
  logic             start_now;

  sscs_char_t       push_data;
  sscs_char_t       head_data;
  logic             head_valid;
  sscs_char_t       cur_char_reg;
  logic [3:0]       frame_bits_reg;

  // Builds the element word for one character, level zero in bit 0
  function automatic logic [7:0] load_word(input sscs_char_t c);
    logic [3:0] len;
    logic [7:0] w;
    len = 4'(CODE_MIN) + {2'b00, c.len_sel};
    w   = c.levels;
    if (!c.universal) begin
      w = {MARK, MARK, c.levels[5:1], MARK};  // see R01 see R02 see R03
    end else begin
      if (len != 4'h8) begin
        w[0] = SPACE;  // see R06
      end
      if (len < 4'h6) begin
        w[6] = MARK;  // see R07
      end
      if (len < 4'h7) begin
        w[7] = MARK;  // see R07
      end
    end
    return w;
  endfunction

  // Pin synchronisers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pin_meta_reg  <= '0;
      pin_sync_reg  <= '0;
      pick_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg  <= {tape_levels, universal_contact, pickup_pulse,
                        universal_sel, len_sel};
      pin_sync_reg  <= pin_meta_reg;
      pick_prev_reg <= pick_s;
    end
  end

  assign lvl_s    = pin_sync_reg[PIN_W-1:5];
  assign univ_s   = pin_sync_reg[4];
  assign pick_s   = pin_sync_reg[3];
  assign usel_s   = pin_sync_reg[2];
  assign lsel_s   = pin_sync_reg[1:0];
  assign pick_evt = pick_s & ~pick_prev_reg;

  // Whole character sampled at once on the timing pulse
  always_comb begin
    push_data           = '0;
    push_data.universal = usel_s;
    push_data.len_sel   = usel_s ? lsel_s : 2'h0;  // see R08
    push_data.levels    = lvl_s;  // see R09
    if (!usel_s) begin
      push_data.levels[7:6] = 2'h0;  // see R01
      push_data.levels[0]   = 1'b0;
    end
  end

  sscs_fifo #(
    .WIDTH ($bits(sscs_char_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_valid  (pick_evt & univ_s),
    .in_ready  (reader_ready),
    .in_data   (push_data),
    .out_valid (head_valid),
    .out_ready (start_now),
    .out_data  (head_data)
  );

  // Stop timer, triggered by the character-rate pulse
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pick_pend_reg <= 1'b0;
    end else if (pick_evt) begin
      pick_pend_reg <= 1'b1;  // see R12
    end else if (state_reg == ST_STOP && !stop_run_reg) begin
      pick_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      stop_run_reg <= 1'b0;
      stop_cnt_reg <= '0;
    end else if (stop_done) begin
      stop_run_reg <= 1'b0;
      stop_cnt_reg <= '0;
    end else if (stop_run_reg) begin
      stop_cnt_reg <= stop_cnt_reg + 1'b1;
    end else if (state_reg == ST_STOP && pick_pend_reg) begin
      stop_run_reg <= 1'b1;  // see R12
    end
  end

  assign stop_done = stop_run_reg && stop_cnt_reg == OSC_W'(STOP_LEN - 1);
  assign start_now = stop_done && head_valid && state_reg == ST_STOP;  // see R16

  // Bit-rate oscillator, held in stop, restarted at start
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      osc_cnt_reg <= '0;
    end else if (state_reg == ST_STOP || osc_cnt_reg == OSC_MAX) begin
      osc_cnt_reg <= '0;  // see R14
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 1'b1;  // see R13
    end
  end

  assign bit_tick = state_reg != ST_STOP && osc_cnt_reg == OSC_MAX;  // see R17

  // Sequencer
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_reg <= ST_STOP;
      idx_reg   <= '0;
    end else begin
      unique case (state_reg)
        ST_STOP: begin
          if (start_now) begin
            state_reg <= ST_START;
          end
        end
        ST_START: begin
          if (bit_tick) begin
            state_reg <= ST_DATA;
            idx_reg   <= '0;
          end
        end
        ST_DATA: begin
          if (bit_tick) begin
            if (idx_reg == LAST_LEVEL) begin
              state_reg <= ST_STOP;  // see R10
            end else begin
              idx_reg <= idx_reg + 1'b1;
            end
          end
        end
        default: begin
          state_reg <= ST_STOP;
        end
      endcase
    end
  end

  // Signal register, marks shift in behind the code
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      shift_reg <= ALL_MARK;
    end else if (start_now) begin
      shift_reg <= load_word(head_data);  // see R05 see R09
    end else if (state_reg == ST_STOP) begin
      shift_reg <= ALL_MARK;  // see R11
    end else if (bit_tick) begin
      shift_reg <= {MARK, shift_reg[7:1]};  // see R10 see R04
    end
  end

  // Output element
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      out_reg <= MARK;
    end else if (start_now) begin
      out_reg <= SPACE;  // see R15
    end else if (bit_tick) begin
      if (state_reg == ST_DATA && idx_reg == LAST_LEVEL) begin
        out_reg <= MARK;  // see R04
      end else begin
        out_reg <= shift_reg[0];  // see R17
      end
    end
  end

  assign serial_out = out_reg;
  assign tx_active  = state_reg != ST_STOP;

  // Checking aids
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cur_char_reg   <= '0;
      frame_bits_reg <= '0;
    end else if (start_now) begin
      cur_char_reg   <= head_data;
      frame_bits_reg <= '0;
    end else if (bit_tick) begin
      frame_bits_reg <= frame_bits_reg + 1'b1;
    end
  end

  property p_idle_mark;
    @(posedge mclk) disable iff (!reset_n)
      state_reg == ST_STOP |-> serial_out == MARK;
  endproperty
  a_idle_mark: assert property (p_idle_mark) // see R16
    else $error("line not mark while idle");

  property p_start_space;
    @(posedge mclk) disable iff (!reset_n)
      start_now |=> !serial_out && state_reg == ST_START;
  endproperty
  a_start_space: assert property (p_start_space) // see R15
    else $error("start bit not space");

  property p_load_word;
    @(posedge mclk) disable iff (!reset_n)
      start_now |=> shift_reg == load_word($past(head_data));
  endproperty
  a_load_word: assert property (p_load_word) // see R09
    else $error("character not loaded whole");

  property p_basic_lvl0;
    @(posedge mclk) disable iff (!reset_n)
      state_reg == ST_START && bit_tick && !cur_char_reg.universal
      |=> serial_out == MARK;
  endproperty
  a_basic_lvl0: assert property (p_basic_lvl0) // see R02
    else $error("basic level zero not mark");

  property p_basic_info;
    @(posedge mclk) disable iff (!reset_n)
      state_reg == ST_DATA && bit_tick && idx_reg < 3'h5
      && !cur_char_reg.universal
      |=> serial_out == $past(cur_char_reg.levels[idx_reg + 3'h1]);
  endproperty
  a_basic_info: assert property (p_basic_info) // see R03
    else $error("basic info level wrong");

  property p_univ_lvl0;
    @(posedge mclk) disable iff (!reset_n)
      state_reg == ST_START && bit_tick && cur_char_reg.universal
      |=> serial_out == ((cur_char_reg.len_sel == LEN_SEL_8)
                          ? cur_char_reg.levels[0] : SPACE);
  endproperty
  a_univ_lvl0: assert property (p_univ_lvl0) // see R06
    else $error("universal level zero wrong");

  property p_unused_high;
    @(posedge mclk) disable iff (!reset_n)
      state_reg == ST_DATA && bit_tick && idx_reg == 3'h5
      && (!cur_char_reg.universal || cur_char_reg.len_sel == 2'h0)
      |=> serial_out == MARK ##0 (state_reg == ST_DATA);
  endproperty
  a_unused_high: assert property (p_unused_high) // see R07
    else $error("unused level six not mark");

  property p_osc_halt;
    @(posedge mclk) disable iff (!reset_n)
      state_reg == ST_STOP |=> osc_cnt_reg == '0 || state_reg != ST_STOP;
  endproperty
  a_osc_halt: assert property (p_osc_halt) // see R14
    else $error("oscillator runs in stop");

  property p_osc_restart;
    @(posedge mclk) disable iff (!reset_n)
      $rose(state_reg == ST_START) |-> osc_cnt_reg == '0;
  endproperty
  a_osc_restart: assert property (p_osc_restart) // see R14
    else $error("oscillator not restarted at start");

  property p_frame_len;
    @(posedge mclk) disable iff (!reset_n)
      $fell(state_reg == ST_DATA)
      |-> frame_bits_reg == 4'(BASIC_FRAME - 1) && serial_out == MARK;
  endproperty
  a_frame_len: assert property (p_frame_len) // see R01
    else $error("frame length wrong");

  property p_stop_trigger;
    @(posedge mclk) disable iff (!reset_n)
      $rose(stop_run_reg) |-> $past(pick_pend_reg);
  endproperty
  a_stop_trigger: assert property (p_stop_trigger) // see R12
    else $error("stop timer started without pulse");

  property p_tick_spacing;
    @(posedge mclk) disable iff (!reset_n)
      bit_tick |-> osc_cnt_reg == OSC_MAX ##1 osc_cnt_reg == '0;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) // see R17
    else $error("bit period wrong");
endmodule

`default_nettype wire

// ==== verification/sscs_tape_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module sscs_tape_model (
  // Clock
  input  wire logic       mclk,
  // Requests from the bench
  input  wire logic       send,
  input  wire logic [7:0] send_levels,
  input  wire logic       send_contact,
  // Reader pins
  output logic [7:0]      tape_levels,
  output logic            universal_contact,
  output logic            pickup_pulse
);
  int unsigned phase;

  // Contacts hold through the capture, then show junk
  initial begin
    phase = 0;
    tape_levels = 8'h00;
    universal_contact = 1'b0;
    pickup_pulse = 1'b0;
    forever begin
      @(negedge mclk);
      if (send && phase == 0) begin
        tape_levels <= send_levels;
        universal_contact <= send_contact;
        pickup_pulse <= 1'b1;
        phase <= 1;
      end else if (phase != 0) begin
        phase <= phase + 1;
        if (phase == 4) begin
          pickup_pulse <= 1'b0;
        end
        if (phase == 8) begin
          tape_levels <= ~tape_levels;
          universal_contact <= 1'b0;
          phase <= 0;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb;
  import sscs_pkg::*;
  localparam int unsigned BC = 16;
  logic       mclk;
  logic       reset_n;
  logic       universal_sel;
  logic [1:0] len_sel;
  logic       send;
  logic [7:0] send_levels;
  logic       send_contact;
  logic [7:0] tape_levels;
  logic       universal_contact;
  logic       pickup_pulse;
  logic       reader_ready;
  logic       serial_out;
  logic       tx_active;
  int         failures;
  int         comparisons;
  int         cycles;

  sscs_serializer #(.BIT_CYCLES(BC)) sscs_serializer_i (
    .mclk(mclk), .reset_n(reset_n), .tape_levels(tape_levels),
    .universal_contact(universal_contact), .pickup_pulse(pickup_pulse),
    .reader_ready(reader_ready), .universal_sel(universal_sel),
    .len_sel(len_sel), .serial_out(serial_out), .tx_active(tx_active)
  );

  sscs_tape_model sscs_tape_model_i (
    .mclk(mclk), .send(send), .send_levels(send_levels),
    .send_contact(send_contact), .tape_levels(tape_levels),
    .universal_contact(universal_contact), .pickup_pulse(pickup_pulse)
  );

  task automatic give_verdict();
    if (failures == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] expect_lv(input logic uni,
      input logic [1:0] ls, input logic [7:0] lv);
    logic [7:0] e;
    e = lv;
    if (!uni) begin
      e[0] = MARK;
      e[6] = MARK;
      e[7] = MARK;
    end else begin
      if (ls != 2'h3) e[0] = SPACE;
      if (ls < 2'h1) e[6] = MARK;
      if (ls < 2'h2) e[7] = MARK;
    end
    return e;
  endfunction

  task automatic pickup(input logic [7:0] lv, input logic ct);
    @(negedge mclk);
    send_levels <= lv;
    send_contact <= ct;
    send <= 1'b1;
    @(negedge mclk);
    send <= 1'b0;
  endtask

  // Samples start, L0..L7 and stop at mid-bit
  task automatic rx_frame(input logic [7:0] lv, input logic timed);
    int         w;
    int         act;
    logic [9:0] s;
    w = 0;
    act = 1;
    s = 10'h000;
    while (serial_out !== 1'b0 && w < 80) begin
      @(negedge mclk);
      w++;
    end
    // Sync and edge detect, pending, then one stop bit
    if (timed) check(16'(w), 16'(BC + 4));
    for (int n = 1; n < 10 * BC; n++) begin
      @(negedge mclk);
      if (tx_active === 1'b1) act++;
      if (n % BC == BC / 2) s[n / BC] = serial_out;
    end
    check({6'h00, s}, {6'h00, 1'b1, lv, 1'b0});
    check(16'(act), 16'(9 * BC));
  endtask

  task automatic check_idle(input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      @(negedge mclk);
      if (serial_out !== 1'b1 || tx_active !== 1'b0) bad = 1'b1;
    end
    check({15'h0000, bad}, 16'h0000);
  endtask

  // Fresh pickup unless a frame starts by itself
  task automatic kick();
    repeat (30) begin
      @(negedge mclk);
      if (serial_out === 1'b0) return;
    end
    pickup(8'h00, 1'b0);
  endtask

  task automatic t_idle();
    check_idle(200);
    check({15'h0000, reader_ready}, 16'h0001);
    pickup(8'hFF, 1'b0);
    check_idle(120);
  endtask

  task automatic t_basic();
    logic [7:0] tbl [3] = '{8'h35, 8'hCA, 8'h00};
    universal_sel <= 1'b0;
    len_sel <= 2'h3;
    foreach (tbl[i]) begin
      repeat (4) @(negedge mclk);
      pickup(tbl[i], 1'b1);
      rx_frame(expect_lv(1'b0, 2'h3, tbl[i]), 1'b1);
    end
  endtask

  task automatic t_univ();
    logic [7:0] lv;
    universal_sel <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      lv = k[0] ? 8'hCA : 8'h35;
      len_sel <= 2'(k >> 1);
      repeat (4) @(negedge mclk);
      pickup(lv, 1'b1);
      rx_frame(expect_lv(1'b1, 2'(k >> 1), lv), 1'b1);
    end
  endtask

  task automatic t_fifo();
    int w;
    w = 0;
    universal_sel <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      pickup(8'(i * 6), 1'b1);
      repeat (8) @(negedge mclk);
    end
    check({15'h0000, reader_ready}, 16'h0000);
    while (tx_active === 1'b1 && w < 300) begin
      @(negedge mclk);
      w++;
    end
    for (int i = 1; i < 9; i++) begin
      kick();
      rx_frame(expect_lv(1'b0, 2'h0, 8'(i * 6)), 1'b0);
    end
    kick();
    check_idle(120);
  endtask

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      failures++;
      give_verdict();
    end
  end

  initial begin
    failures = 0;
    comparisons = 0;
    reset_n = 1'b0;
    universal_sel = 1'b0;
    len_sel = 2'h0;
    send = 1'b0;
    send_levels = 8'h00;
    send_contact = 1'b0;
    repeat (16) @(negedge mclk);
    reset_n <= 1'b1;
    t_idle();
    t_basic();
    t_univ();
    t_fifo();
    give_verdict();
  end
endmodule

`default_nettype wire
